// *** dv/test_osc_switch_ctrl.sv ***
// self-checking testbench for the oscillator switch controller
`timescale 1ns/10ps
`default_nettype none
module test_osc_switch_ctrl;
    import osc_switch_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        core_clk;              // 125 MHz core clock
    logic        nrst;                  // synchronous reset, active low
    bus_req_s    bus;                   // register port request
    logic [15:0] rdata;                 // read data, one cycle after strobe
    logic [7:0]  osc_running;           // follows the enables one cycle late
    logic [7:0]  osc_new_clk;           // slow source clock, all lanes alike
    logic [7:0]  src_is_xtal;           // source 4 needs the startup timer
    logic [7:0]  src_uses_pll;          // source 3 runs through the pll
    logic        startup_timer_done;
    logic        pll_locked;
    logic        clk_fail_evt;
    logic        watchdog_en;
    logic        fail_safe_en;
    logic        secondary_osc_keep_on;
    logic [7:0]  osc_enable;
    logic [2:0]  sys_clk_sel;
    logic        irq;
    logic [1:0]  div;                   // divider for the slow source clock
    logic [15:0] rd_val;                // last value read
    int          ticks;                 // new-clock edges seen while waiting
    int          fail_count;
    int          tests_run;
    // ------------------------------------------------------------
    // design under test
    // ------------------------------------------------------------
    osc_switch_ctrl dut_u (
        .core_clk              (core_clk),
        .nrst                  (nrst),
        .bus                   (bus),
        .rdata                 (rdata),
        .osc_running           (osc_running),
        .osc_new_clk           (osc_new_clk),
        .src_is_xtal           (src_is_xtal),
        .src_uses_pll          (src_uses_pll),
        .startup_timer_done    (startup_timer_done),
        .pll_locked            (pll_locked),
        .clk_fail_evt          (clk_fail_evt),
        .watchdog_en           (watchdog_en),
        .fail_safe_en          (fail_safe_en),
        .secondary_osc_keep_on (secondary_osc_keep_on),
        .osc_enable            (osc_enable),
        .sys_clk_sel           (sys_clk_sel),
        .irq                   (irq)
    );
    // ------------------------------------------------------------
    // clocks and far-side behaviour
    // ------------------------------------------------------------
    // core clock, 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // slow source clock, one sixth of core rate; still in reset
    always @(posedge core_clk) begin
        if (!nrst) begin
            div         <= 2'h0;
            osc_new_clk <= 8'h00;
        end else if (div == 2'h2) begin
            div         <= 2'h0;
            osc_new_clk <= ~osc_new_clk;
        end else begin
            div <= div + 2'h1;
        end
        osc_running <= osc_enable;      // an enabled source reports running a cycle later
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // prints the verdict and ends the run
    task automatic wrap_up;
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // compares one value, counts and reports a mismatch
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [1:0] be, input logic [15:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, be: be, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus <= '0;
    endtask
    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 16'h0000, be: 2'h3, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus <= '0;
        #1;
        d = rdata;
    endtask
    // reads a register and compares the masked bits
    task automatic rd_chk(input string name, input logic [3:0] a, input logic [15:0] m,
                          input logic [15:0] exp);
        rd(a, rd_val);
        chk(name, exp, rd_val & m);
    endtask
    // high-lane unlock, next source, low-lane unlock, then the switch request
    task automatic start_switch(input logic [2:0] s);
        wr(ADDR_CTRL, 2'h2, {KEY_HI_1, 8'h00});
        wr(ADDR_CTRL, 2'h2, {KEY_HI_2, 8'h00});
        wr(ADDR_CTRL, 2'h2, {5'h00, s, 8'h00});
        wr(ADDR_CTRL, 2'h1, {8'h00, KEY_LO_1});
        wr(ADDR_CTRL, 2'h1, {8'h00, KEY_LO_2});
        wr(ADDR_CTRL, 2'h1, 16'h0001);
    endtask
    // bounded wait for a source; counts new-clock rises
    task automatic wait_sel(input logic [2:0] s, output int t);
        logic prev;
        int   n;
        t    = 0;
        n    = 0;
        prev = osc_new_clk[0];
        while (sys_clk_sel !== s && n < 400) begin
            @(posedge core_clk);
            #1;
            if (osc_new_clk[0] && !prev) begin
                t++;
            end
            prev = osc_new_clk[0];
            n++;
        end
        repeat (4) @(posedge core_clk);  // let the old source be stopped
        #1;
    endtask
    // ------------------------------------------------------------
    // watchdog: the whole run needs a few thousand cycles at most
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        fail_count = 0;
        tests_run = 0;
        nrst = 1'b0;
        bus = '0;
        src_is_xtal = 8'h10;
        src_uses_pll = 8'h08;
        startup_timer_done = 1'b0;
        pll_locked = 1'b0;
        clk_fail_evt = 1'b0;
        watchdog_en = 1'b0;
        fail_safe_en = 1'b0;
        secondary_osc_keep_on = 1'b0;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        // state straight after reset
        chk("osc_enable", 16'h0001, {8'h00, osc_enable});
        chk("sys_clk_sel", 16'h0000, {13'h0000, sys_clk_sel});
        chk("irq", 16'h0000, {15'h0000, irq});
        rd_chk("ctrl", ADDR_CTRL, 16'hffff, CTRL_RESET);
        rd_chk("unmapped", 4'hc, 16'hffff, 16'h0000);
        // a fail-safe event raises the read-only fail flag
        @(posedge core_clk);
        clk_fail_evt <= 1'b1;
        repeat (4) @(posedge core_clk);
        clk_fail_evt <= 1'b0;
        rd_chk("fail flag", ADDR_CTRL, 16'h0008, 16'h0008);
        // writes without keys, or keys split by a read, are dropped
        wr(ADDR_CTRL, 2'h2, 16'h0300);
        wr(ADDR_CTRL, 2'h2, {KEY_HI_1, 8'h00});
        rd(ADDR_CTRL, rd_val);
        wr(ADDR_CTRL, 2'h2, {KEY_HI_2, 8'h00});
        wr(ADDR_CTRL, 2'h2, 16'h0300);
        wr(ADDR_CTRL, 2'h1, 16'h0001);
        rd_chk("refused", ADDR_CTRL, 16'h0701, 16'h0000);
        // redundant switch: request cleared, abort reported, nothing else touched
        start_switch(3'h0);
        repeat (10) @(posedge core_clk);
        rd_chk("redundant", ADDR_CTRL, 16'h7709, 16'h0008);
        rd_chk("abort status", ADDR_IRQ_STAT, 16'h0003, 16'h0002);
        chk("irq masked", 16'h0000, {15'h0000, irq});
        wr(ADDR_IRQ_MASK, 2'h3, 16'h0003);
        #1;
        chk("irq unmasked", 16'h0001, {15'h0000, irq});
        wr(ADDR_IRQ_STAT, 2'h3, 16'h0002);
        #1;
        chk("irq cleared", 16'h0000, {15'h0000, irq});
        // pll source: flags cleared, source enabled, held until lock
        start_switch(3'h3);
        repeat (40) @(posedge core_clk);
        #1;
        chk("enable new", 16'h0009, {8'h00, osc_enable});
        chk("held sel", 16'h0000, {13'h0000, sys_clk_sel});
        rd_chk("waiting", ADDR_CTRL, 16'h7729, 16'h0301);
        @(posedge core_clk);
        pll_locked <= 1'b1;
        wait_sel(3'h3, ticks);
        chk("settle ticks", 16'h0001, {15'h0000, (ticks >= 10 && ticks <= 12)});
        chk("pll sel", 16'h0003, {13'h0000, sys_clk_sel});
        chk("old stopped", 16'h0008, {8'h00, osc_enable});
        rd_chk("switched", ADDR_CTRL, 16'h7721, 16'h3320);
        rd_chk("done status", ADDR_IRQ_STAT, 16'h0003, 16'h0001);
        chk("irq done", 16'h0001, {15'h0000, irq});
        wr(ADDR_IRQ_MASK, 2'h3, 16'h0000);
        #1;
        chk("irq mask off", 16'h0000, {15'h0000, irq});
        wr(ADDR_IRQ_STAT, 2'h3, 16'h0003);
        // plain source: the pll source is stopped afterwards
        start_switch(SRC_LOW_POWER_RC_OSC);
        wait_sel(SRC_LOW_POWER_RC_OSC, ticks);
        chk("rc sel", {13'h0000, SRC_LOW_POWER_RC_OSC}, {13'h0000, sys_clk_sel});
        chk("pll stopped", 16'h0020, {8'h00, osc_enable});
        // crystal source waits for its timer; low-power rc kept for the watchdog
        @(posedge core_clk);
        watchdog_en <= 1'b1;
        start_switch(SRC_SECONDARY_OSC);
        repeat (100) @(posedge core_clk);
        #1;
        chk("xtal held", {13'h0000, SRC_LOW_POWER_RC_OSC}, {13'h0000, sys_clk_sel});
        @(posedge core_clk);
        startup_timer_done <= 1'b1;
        wait_sel(SRC_SECONDARY_OSC, ticks);
        chk("xtal sel", {13'h0000, SRC_SECONDARY_OSC}, {13'h0000, sys_clk_sel});
        chk("rc kept", 16'h0030, {8'h00, osc_enable});
        // secondary oscillator kept on while its keep-on bit is set
        @(posedge core_clk);
        secondary_osc_keep_on <= 1'b1;
        start_switch(3'h0);
        wait_sel(3'h0, ticks);
        chk("back sel", 16'h0000, {13'h0000, sys_clk_sel});
        chk("sec kept", 16'h0011, {8'h00, osc_enable & 8'h11});
        wrap_up();
    end
endmodule // test_osc_switch_ctrl
`default_nettype wire

// *** hdl/osc_switch_ctrl.sv ***
// oscillator switch controller: control register, switch sequencer, interrupts
`timescale 1ns/10ps
`default_nettype none
module osc_switch_ctrl (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      nrst,
    // register port
    input  wire osc_switch_pkg::bus_req_s  bus,
    output logic [15:0]                    rdata,
    // oscillator status pins, asynchronous
    input  wire logic [7:0]                osc_running,   // per source
    input  wire logic [7:0]                osc_new_clk,   // raw clock of each source
    input  wire logic [7:0]                src_is_xtal,   // source needs startup timer
    input  wire logic [7:0]                src_uses_pll,
    input  wire logic                      startup_timer_done,
    input  wire logic                      pll_locked,
    input  wire logic                      clk_fail_evt,  // fail-safe monitor event
    // keep-on conditions
    input  wire logic                      watchdog_en,
    input  wire logic                      fail_safe_en,
    input  wire logic                      secondary_osc_keep_on,
    // oscillator control
    output logic [7:0]                     osc_enable,
    output logic [2:0]                     sys_clk_sel,
    output logic                           irq
);
    import osc_switch_pkg::*;
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // status pins cross clock domains:
    // two flops before logic reads them; src_is_xtal and src_uses_pll are read directly
    localparam int SYN_W = 8 + 8 + 3;
    logic [SYN_W-1:0] syn1_r;
    logic [SYN_W-1:0] syn2_r;
    logic [7:0]       clk_d_r;   // previous synchronised new clocks
    logic [SYN_W-1:0] syn_in;
    assign syn_in = {osc_running, osc_new_clk, startup_timer_done, pll_locked, clk_fail_evt};
    // first stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            syn1_r  <= '0;
            syn2_r  <= '0;
            clk_d_r <= 8'h00;
        end else begin
            syn1_r  <= syn_in;
            syn2_r  <= syn1_r;
            clk_d_r <= syn2_r[10:3];
        end
    end
    // synchronised views
    logic [7:0] run_s;
    logic [7:0] clk_s;
    logic       ost_s;
    logic       lock_s;
    logic       fail_s;
    assign run_s  = syn2_r[18:11];
    assign clk_s  = syn2_r[10:3];
    assign ost_s  = syn2_r[2];
    assign lock_s = syn2_r[1];
    assign fail_s = syn2_r[0];
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    // fields first, then bookkeeping
    logic [2:0]        cur_r, cur_nxt;         // current_osc_sel
    logic [2:0]        next_r, next_nxt;       // next_osc_sel
    logic              req_r, req_nxt;         // switch_request
    logic              lock_r, lock_nxt;       // pll lock flag
    logic              fail_r, fail_nxt;       // clock_fail_flag
    logic [7:0]        en_r, en_nxt;           // oscillator enables
    logic [IRQ_W-1:0]  ist_r, ist_nxt;         // sticky events
    logic [IRQ_W-1:0]  imsk_r, imsk_nxt;
    logic [15:0]       rdata_r, rdata_nxt;
    sw_state_e         st_r, st_nxt;
    logic [2:0]        old_r, old_nxt;         // source being left
    // ------------------------------------------------------------
    // byte lane unlock gates
    // ------------------------------------------------------------
    // any strobe is an access; one that is not the next key
    // drops a half-entered key sequence
    logic acc;
    logic ctrl_wr;
    logic hi_open;
    logic lo_open;
    assign acc     = bus.wr || bus.rd;
    assign ctrl_wr = bus.wr && bus.addr == ADDR_CTRL;
    unlock_gate u_hi (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .acc       (acc),
        .lane_wr   (ctrl_wr && bus.be[1]),
        .lane_data (bus.wdata[15:8]),
        .key1      (KEY_HI_1),
        .key2      (KEY_HI_2),
        .open      (hi_open)
    );
    unlock_gate u_lo (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .acc       (acc),
        .lane_wr   (ctrl_wr && bus.be[0]),
        .lane_data (bus.wdata[7:0]),
        .key1      (KEY_LO_1),
        .key2      (KEY_LO_2),
        .open      (lo_open)
    );
    // writes land only through an open gate;
    // key writes store nothing
    logic hi_take;
    logic lo_take;
    assign hi_take = hi_open && ctrl_wr && bus.be[1];
    assign lo_take = lo_open && ctrl_wr && bus.be[0];
    // ------------------------------------------------------------
    // settle counter on the new source clock
    // ------------------------------------------------------------
    // limitation: the new source must run
    // far below core_clk, or edges are lost
    logic new_tick;
    logic settled;
    assign new_tick = clk_s[next_r] && !clk_d_r[next_r];
    settle_counter u_settle (
        .core_clk (core_clk),
        .nrst     (nrst),
        .run      (st_r == SW_SETTLE),
        .tick     (new_tick),
        .expired  (settled)
    );
    // ------------------------------------------------------------
    // switch sequencer and register next state
    // ------------------------------------------------------------
    // the sequencer never holds the bus; software keeps running
    always_comb begin
        cur_nxt  = cur_r;
        next_nxt = next_r;
        req_nxt  = req_r;
        lock_nxt = lock_r;
        fail_nxt = fail_r || fail_s;
        en_nxt   = en_r;
        st_nxt   = st_r;
        old_nxt  = old_r;
        ist_nxt  = ist_r;
        imsk_nxt = imsk_r;
        // writes first; the case may override
        // next source frozen while busy
        if (hi_take && st_r == SW_IDLE) next_nxt = bus.wdata[NXT_LSB +: 3];
        if (lo_take && bus.wdata[REQ_BIT]) req_nxt = 1'b1;
        if (bus.wr && bus.addr == ADDR_IRQ_MASK) imsk_nxt = bus.wdata[IRQ_W-1:0];
        // clear before the case: set wins
        if (bus.wr && bus.addr == ADDR_IRQ_STAT) ist_nxt = ist_r & ~bus.wdata[IRQ_W-1:0];
        if (st_r == SW_WAIT && src_uses_pll[next_r] && lock_s) lock_nxt = 1'b1;
        case (st_r)
            SW_IDLE: begin
                // wait for a request
                if (req_r) st_nxt = SW_START;
            end
            SW_START: begin
                if (cur_r == next_r) begin
                    // redundant: drop and report
                    req_nxt = 1'b0;
                    ist_nxt[IRQ_ABORT] = 1'b1;
                    st_nxt  = SW_IDLE;
                end else begin
                    // valid: clear flags, start source
                    lock_nxt = 1'b0;
                    // a fail event now beats the clear
                    fail_nxt = fail_s;
                    en_nxt[next_r] = 1'b1;
                    old_nxt = cur_r;
                    st_nxt  = SW_WAIT;
                end
            end
            SW_WAIT: begin
                // crystal waits for startup timer, pll waits for lock
                if (run_s[next_r]
                    && (!src_is_xtal[next_r] || ost_s)
                    && (!src_uses_pll[next_r] || lock_r))
                    st_nxt = SW_SETTLE;
            end
            SW_SETTLE: begin
                // ten new-clock ticks, then change
                if (settled) begin
                    cur_nxt = next_r;
                    req_nxt = 1'b0;
                    st_nxt  = SW_DONE;
                end
            end
            SW_DONE: begin
                // old source kept only when a keeper still needs it
                if (!((old_r == SRC_LOW_POWER_RC_OSC && (watchdog_en || fail_safe_en))
                      || (old_r == SRC_SECONDARY_OSC && secondary_osc_keep_on)))
                    en_nxt[old_r] = 1'b0;
                ist_nxt[IRQ_DONE] = 1'b1;
                st_nxt = SW_IDLE;
            end
            // unused codes fall back to idle
            default: st_nxt = SW_IDLE;
        endcase
        // never stop the live source
        en_nxt[cur_nxt] = 1'b1;  // the running system source is never stopped
    end
    // ------------------------------------------------------------
    // read mux, data one cycle after the strobe
    // ------------------------------------------------------------
    // idle and unmapped reads give zero
    // registered: costs a cycle, no glitches
    always_comb begin
        rdata_nxt = 16'h0000;
        if (bus.rd) begin
            case (bus.addr)
                ADDR_CTRL: begin
                    rdata_nxt[CUR_LSB +: 3] = cur_r;
                    rdata_nxt[NXT_LSB +: 3] = next_r;
                    rdata_nxt[LOCK_BIT]     = lock_r;
                    rdata_nxt[FAIL_BIT]     = fail_r;
                    rdata_nxt[REQ_BIT]      = req_r;
                end
                ADDR_IRQ_STAT: rdata_nxt[IRQ_W-1:0] = ist_r;
                ADDR_IRQ_MASK: rdata_nxt[IRQ_W-1:0] = imsk_r;
                default:       rdata_nxt = 16'h0000;
            endcase
        end
    end
    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    // every register runs on every edge
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            // source zero selected and running
            cur_r   <= CTRL_RESET[CUR_LSB +: 3];
            next_r  <= CTRL_RESET[NXT_LSB +: 3];
            req_r   <= 1'b0;
            lock_r  <= 1'b0;
            fail_r  <= 1'b0;
            en_r    <= 8'h01;   // source zero runs out of reset
            ist_r   <= '0;
            imsk_r  <= '0;
            rdata_r <= 16'h0000;
            st_r    <= SW_IDLE;
            old_r   <= 3'h0;
        end else begin
            cur_r   <= cur_nxt;
            next_r  <= next_nxt;
            req_r   <= req_nxt;
            lock_r  <= lock_nxt;
            fail_r  <= fail_nxt;
            en_r    <= en_nxt;
            ist_r   <= ist_nxt;
            imsk_r  <= imsk_nxt;
            rdata_r <= rdata_nxt;
            st_r    <= st_nxt;
            old_r   <= old_nxt;
        end
    end
    // outputs from flops; irq is a level
    assign rdata       = rdata_r;
    assign osc_enable  = en_r;
    assign sys_clk_sel = cur_r;
    assign irq         = |(ist_r & imsk_r);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_equal_abort: assert property (@(posedge core_clk) disable iff (!nrst)
        (st_r == SW_START && cur_r == next_r) |=> !req_r && st_r == SW_IDLE && $stable(cur_r))
        else $error("redundant switch not abandoned");
    a_flags_cleared: assert property (@(posedge core_clk) disable iff (!nrst)
        (st_r == SW_START && cur_r != next_r) |=> !lock_r && (!fail_r || $past(fail_s)))
        else $error("lock or fail flag not cleared at switch start");
    a_new_enabled: assert property (@(posedge core_clk) disable iff (!nrst)
        (st_r == SW_START && cur_r != next_r) |=> osc_enable[next_r])
        else $error("new oscillator not enabled");
    a_xtal_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        (st_r == SW_WAIT && src_is_xtal[next_r] && !ost_s) |=> st_r != SW_SETTLE)
        else $error("crystal switch left wait before timer expiry");
    a_pll_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        (st_r == SW_WAIT && src_uses_pll[next_r] && !lock_r) |=> st_r != SW_SETTLE)
        else $error("pll switch left wait before lock");
    a_cur_stable: assert property (@(posedge core_clk) disable iff (!nrst)
        (st_r != SW_SETTLE) |=> $stable(cur_r))
        else $error("current source changed outside changeover");
    a_done_copy: assert property (@(posedge core_clk) disable iff (!nrst)
        (st_r == SW_SETTLE && settled) |=> cur_r == next_r && !req_r)
        else $error("changeover did not copy source or clear request");
    a_hi_locked: assert property (@(posedge core_clk) disable iff (!nrst)
        (ctrl_wr && bus.be[1] && !hi_open) |=> $stable(next_r))
        else $error("next source changed without unlock");
    // refused low write starts nothing
    a_lo_locked: assert property (@(posedge core_clk) disable iff (!nrst)
        (ctrl_wr && bus.be[0] && !lo_open && !req_r && st_r == SW_IDLE) |=> !req_r)
        else $error("request set while locked");
    a_req_taken: assert property (@(posedge core_clk) disable iff (!nrst)
        (lo_take && bus.wdata[REQ_BIT] && st_r == SW_IDLE) |=> req_r)
        else $error("request write lost");
    // old source other than the low-power rc or secondary stopped after changeover
    a_old_stopped: assert property (@(posedge core_clk) disable iff (!nrst)
        (st_r == SW_DONE && old_r != SRC_LOW_POWER_RC_OSC && old_r != SRC_SECONDARY_OSC) |=> !osc_enable[old_r])
        else $error("old oscillator left running");
    a_lock_set: assert property (@(posedge core_clk) disable iff (!nrst)
        (st_r == SW_WAIT && src_uses_pll[next_r] && lock_s) |=> lock_r)
        else $error("lock flag not set");
endmodule // osc_switch_ctrl
`default_nettype wire

// *** hdl/osc_switch_pkg.sv ***
// constants and types for the oscillator switch controller
package osc_switch_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL       = 4'h0;  // osc_control_reg
    localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h4;  // sticky events
    localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h8;  // event mask
    localparam logic [15:0] CTRL_RESET      = 16'h0000;
    // bit positions of osc_control_reg
    localparam int CUR_LSB   = 12;
    localparam int NXT_LSB   = 8;
    localparam int LOCK_BIT  = 5;
    localparam int FAIL_BIT  = 3;
    localparam int REQ_BIT   = 0;
    // unlock keys
    localparam logic [7:0] KEY_HI_1 = 8'h78;
    localparam logic [7:0] KEY_HI_2 = 8'h9a;
    localparam logic [7:0] KEY_LO_1 = 8'h46;
    localparam logic [7:0] KEY_LO_2 = 8'h57;
    // ------------------------------------------------------------
    // sources and timing
    // ------------------------------------------------------------
    localparam int          NUM_SRC      = 8;
    localparam logic [2:0]  SRC_LOW_POWER_RC_OSC     = 3'h5;   // low-power rc source code
    localparam logic [2:0]  SRC_SECONDARY_OSC     = 3'h4;   // secondary oscillator code
    localparam logic [3:0]  SETTLE_COUNT = 4'ha;   // new-clock cycles before change
    // interrupt status bits
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_ABORT = 1;
    localparam int IRQ_W     = 2;
    // ------------------------------------------------------------
    // bus carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic [1:0]  be;     // byte lanes: bit1 high byte, bit0 low byte
        logic        wr;
        logic        rd;
    } bus_req_s;
    typedef enum logic [2:0] {
        SW_IDLE   = 3'b000,
        SW_START  = 3'b001,
        SW_WAIT   = 3'b010,
        SW_SETTLE = 3'b011,
        SW_DONE   = 3'b100
    } sw_state_e;
endpackage

// *** hdl/settle_counter.sv ***
// counter of new-source clock ticks before changeover
`timescale 1ns/10ps
`default_nettype none
module settle_counter (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // control
    input  wire logic run,       // counting enabled
    input  wire logic tick,      // synchronised new-clock rising edge
    // result
    output logic      expired
);
    import osc_switch_pkg::*;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    // ------------------------------------------------------------
    // tick counter
    // ------------------------------------------------------------
    always_comb begin
        cnt_nxt = cnt_r;
        if (!run)                             cnt_nxt = 4'h0;
        else if (tick && cnt_r != SETTLE_COUNT) cnt_nxt = cnt_r + 4'h1;
    end
    always_ff @(posedge core_clk) begin
        if (!nrst) cnt_r <= 4'h0;
        else       cnt_r <= cnt_nxt;
    end
    assign expired = run && (cnt_r == SETTLE_COUNT);
endmodule // settle_counter
`default_nettype wire

// *** hdl/unlock_gate.sv ***
// two-key unlock detector for one byte lane of the control register
`timescale 1ns/10ps
`default_nettype none
module unlock_gate (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    // lane access
    input  wire logic       acc,      // any bus access this cycle
    input  wire logic       lane_wr,  // write to this lane of the control register
    input  wire logic [7:0] lane_data,
    input  wire logic [7:0] key1,
    input  wire logic [7:0] key2,
    // result
    output logic            open      // next lane write is accepted
);
    import osc_switch_pkg::*;
    logic [1:0] st_r;   // 0 idle, 1 first key seen, 2 open
    logic [1:0] st_nxt;
    // ------------------------------------------------------------
    // key sequencer
    // ------------------------------------------------------------
    // any access that is not the expected key drops the sequence
    always_comb begin
        st_nxt = st_r;
        if (acc) begin
            if (st_r == 2'h0 && lane_wr && lane_data == key1) begin
                st_nxt = 2'h1;
            end else if (st_r == 2'h1 && lane_wr && lane_data == key2) begin
                st_nxt = 2'h2;
            end else if (st_r != 2'h0 && lane_wr && lane_data == key1) begin
                st_nxt = 2'h1;  // restart on a fresh first key
            end else begin
                st_nxt = 2'h0;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (!nrst) st_r <= 2'h0;
        else       st_r <= st_nxt;
    end
    assign open = (st_r == 2'h2);
    a_open_after_keys: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(open) |-> $past(acc) && $past(lane_wr) && $past(lane_data) == key2)
        else $error("unlock opened without second key");
endmodule // unlock_gate
`default_nettype wire
